// File: pkg/cws_pkg.sv
// constants shared by the ct wiring supervision design
// assumes one 250 MHz clock, values in hundredths
package cws_pkg;

  // ==========================================
  // timing
  localparam int unsigned CLK_HZ      = 250_000_000;
  localparam int unsigned HZ_PER_MHZ  = 1_000_000;
  localparam int unsigned PCYC_US     = 5000; // 5 ms
  localparam int unsigned PCYC_CLKS   =
    CLK_HZ / HZ_PER_MHZ * PCYC_US;
  localparam int unsigned DLY_STEP_MS = 5;
  localparam int unsigned DLY_MAX_S   = 1800;
  localparam int unsigned MS_PER_S    = 1000;
  localparam int unsigned DLY_MAX     =
    DLY_MAX_S * MS_PER_S / DLY_STEP_MS;
  localparam int unsigned DLY_DEF_MS  = 500;

  // ==========================================
  // widths and scaling
  localparam int unsigned MAG_W  = 16;
  localparam int unsigned ANG_W  = 18;
  localparam int unsigned DW     = 32;
  localparam int unsigned AW     = 8;
  localparam int unsigned CW     = 48;
  localparam int unsigned N_SET  = 6;
  localparam logic [CW-1:0] PCT  = 48'h64;   // 100
  localparam logic [CW-1:0] REL_LO = 48'h61; // 97
  localparam logic [CW-1:0] REL_HI = 48'h67; // 103
  localparam logic [CW-1:0] FULL = 48'h2710; // 100.00 %
  localparam logic signed [ANG_W-1:0] HALF_TURN = 18'sh0_4650;
  localparam logic signed [ANG_W-1:0] FULL_TURN = 18'sh0_8CA0;

  // ==========================================
  // register offsets
  localparam logic [AW-1:0] A_CTRL = 8'h00;
  localparam logic [AW-1:0] A_STAT = 8'h04;
  localparam logic [AW-1:0] A_SDIF = 8'h08;
  localparam logic [AW-1:0] A_ADIF = 8'h0C;
  localparam logic [AW-1:0] A_UNBA = 8'h10;
  localparam logic [AW-1:0] A_GRP0 = 8'h20;
  localparam logic [AW-1:0] A_GRP1 = 8'h40;

  // setting word indices inside a group
  localparam int unsigned S_HIGH = 0;
  localparam int unsigned S_LOW  = 1;
  localparam int unsigned S_RAT  = 2;
  localparam int unsigned S_SEQ  = 3;
  localparam int unsigned S_SUM  = 4;
  localparam int unsigned S_DLY  = 5;

  // setting defaults
  localparam logic [DW-1:0] D_HIGH = 32'h78;   // 1.20 x In
  localparam logic [DW-1:0] D_LOW  = 32'h0A;   // 0.10 x In
  localparam logic [DW-1:0] D_RAT  = 32'h3E8;  // 10.00 %
  localparam logic [DW-1:0] D_SEQ  = 32'h1324; // 49.00 %
  localparam logic [DW-1:0] D_SUM  = 32'h0A;   // 0.10 x In
  localparam logic [DW-1:0] D_DLY  =
    DW'(DLY_DEF_MS / DLY_STEP_MS);

  // control fields
  localparam int unsigned C_RES = 0;
  localparam int unsigned C_POL = 2;
  localparam int unsigned C_GRP = 3;
  localparam logic [1:0] RES_ONE = 2'h1;
  localparam logic [1:0] RES_TWO = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE, ST_START, ST_BLOCKED
  } cws_state_e;

endpackage : cws_pkg

// File: logic/cws_setting_bank.sv
// two setting groups, six words each
// assumes writes from the owner's register port
`timescale 1ns/1ps
`default_nettype none

module cws_setting_bank (
  input  wire logic                        clk,     // 250 MHz
  input  wire logic                        rst_b,   // sync reset
  input  wire logic                        wr_en,   // word write
  input  wire logic                        wr_grp,  // target group
  input  wire logic [2:0]                  wr_idx,  // word index
  input  wire logic [cws_pkg::DW-1:0]      wr_data, // new value
  input  wire logic                        act_grp, // running group
  output logic [2*cws_pkg::N_SET*32-1:0]   all_q,   // every word
  output logic [cws_pkg::N_SET*32-1:0]     act_q    // active copy
);

  // ==========================================
  // reset values of one group
  localparam logic [cws_pkg::N_SET*32-1:0] DEF = {
    cws_pkg::D_DLY, cws_pkg::D_SUM, cws_pkg::D_SEQ,
    cws_pkg::D_RAT, cws_pkg::D_LOW, cws_pkg::D_HIGH};

  // ==========================================
  // storage; group switch lands on a clean edge
  genvar g;
  generate
    for (g = 0; g < 2 * cws_pkg::N_SET; g++)
    begin : g_word
      always_ff @(posedge clk)
      begin
        if (!rst_b)
          all_q[g*32 +: 32] <= DEF[(g % cws_pkg::N_SET)*32 +: 32];
        else if (wr_en && (32'(wr_grp) * cws_pkg::N_SET
                 + 32'(wr_idx)) == g)
          all_q[g*32 +: 32] <= wr_data;
      end
    end
  endgenerate

  // active group copy, reselected every cycle
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      act_q <= DEF;
    else
      act_q <= act_grp ? all_q[2*cws_pkg::N_SET*32-1 -: cws_pkg::N_SET*32]
                       : all_q[cws_pkg::N_SET*32-1:0];
  end

endmodule : cws_setting_bank

`default_nettype wire

// File: logic/cws_top.sv
// current-transformer wiring supervision core
// assumes magnitudes and angles from same-clock channels,
// refreshed every 5 ms, and a same-clock blocking level
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// [RQ1] ratio of each magnitude to its setting
// [RQ2] release at 97 or 103 percent
// [RQ3] one shared threshold, any phase counts
// [RQ4] any phase above ceiling stops supervision
// [RQ5] some phase must exceed floor
// [RQ6] min/max ratio must be below setting
// [RQ7] sequence ratio must exceed setting
// [RQ8] residual mismatch must exceed setting
// [RQ9] alarm delay in 5 ms steps
// [RQ10] sample blocking at each program cycle
// [RQ11] pickup unblocked raises start, starts timing
// [RQ12] pickup while blocked raises blocked only
// [RQ13] blocking drops start like pickup reset
// [RQ14] source blocks 5 ms before expiry
// [RQ15] definite time delay only
// [RQ16] setting group switchable while running
// [RQ17] expose magnitude and angle difference
// [RQ18] expose residual unbalance angle
// [RQ19] timing only while all conditions hold
// [RQ20] inputs are 5 ms fundamental magnitudes
// [RQ21] residual source and polarity selectable
// [RQ22] alarm at delay, clears with start
// [RQ23] integer hundredths, exact comparisons
module cws_top #(
  parameter int unsigned PCYC_CLKS = cws_pkg::PCYC_CLKS // clocks per cycle
) (
  input  wire logic                          clk,       // 250 MHz
  input  wire logic                          rst_b,     // sync reset
  input  wire logic [cws_pkg::AW-1:0]        addr,      // byte address
  input  wire logic [cws_pkg::DW-1:0]        wr_data,   // write data
  input  wire logic                          wr_stb,    // write strobe
  input  wire logic                          rd_stb,    // read strobe
  output logic [cws_pkg::DW-1:0]             rd_data,   // next-cycle data
  input  wire logic [3*cws_pkg::MAG_W-1:0]   meas_mag,  // phase 1..3
  input  wire logic [cws_pkg::MAG_W-1:0]     res_one,   // residual ch 1
  input  wire logic [cws_pkg::MAG_W-1:0]     res_two,   // residual ch 2
  input  wire logic [cws_pkg::MAG_W-1:0]     seq_pos,   // positive seq
  input  wire logic [cws_pkg::MAG_W-1:0]     seq_neg,   // negative seq
  input  wire logic [cws_pkg::MAG_W-1:0]     sum_mag,   // phase sum mag
  input  wire logic [cws_pkg::MAG_W-1:0]     sum_ang,   // phase sum angle
  input  wire logic [cws_pkg::MAG_W-1:0]     res_one_a, // ch 1 angle
  input  wire logic [cws_pkg::MAG_W-1:0]     res_two_a, // ch 2 angle
  input  wire logic [cws_pkg::ANG_W-1:0]     unbal_ang, // signed, comp.
  input  wire logic                          block_in,  // blocking level
  output logic                               start,     // start
  output logic                               alarm,     // alarm
  output logic                               blocked    // blocked
);

  localparam int unsigned CW = cws_pkg::CW;
  localparam int unsigned MW = cws_pkg::MAG_W;

  // elaboration check on the cycle length
  if (PCYC_CLKS < 2)
    $error("PCYC_CLKS must be at least 2");

  // ==========================================
  // compare helpers with built-in hysteresis
  // held "above": keep while a*100 >= b*97
  function automatic logic cmp_over(
    input logic [CW-1:0] a,
    input logic [CW-1:0] b,
    input logic          held);
    cmp_over = held ? (a * cws_pkg::PCT >= b * cws_pkg::REL_LO)
                    : (a > b);
  endfunction : cmp_over

  // held "below": keep while a*100 <= b*103
  function automatic logic cmp_under(
    input logic [CW-1:0] a,
    input logic [CW-1:0] b,
    input logic          held);
    cmp_under = held ? (a * cws_pkg::PCT <= b * cws_pkg::REL_HI)
                     : (a < b);
  endfunction : cmp_under

  // address falls inside one setting group
  function automatic logic grp_hit(
    input logic [cws_pkg::AW-1:0] a,
    input logic [cws_pkg::AW-1:0] base);
    grp_hit = (a >= base) &&
              (a < base + cws_pkg::AW'(4 * cws_pkg::N_SET)) &&
              (a[1:0] == 2'h0);
  endfunction : grp_hit

  // ==========================================
  // program cycle divider
  logic [31:0] div_r;     // clocks into cycle
  logic        tick;      // one per program cycle

  assign tick = (div_r == PCYC_CLKS - 1);

  // free-running 5 ms enable
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      div_r <= '0;
    else
      div_r <= tick ? '0 : div_r + 32'h1; // [RQ20]
  end

  // ==========================================
  // register port decode
  logic [cws_pkg::DW-1:0] ctrl_r;   // control word
  logic        hit0;                // group 0 window
  logic        hit1;                // group 1 window
  logic        set_wr;              // setting write
  logic [2:0]  set_idx;             // word index
  logic [2*cws_pkg::N_SET*32-1:0] all_q; // stored words
  logic [cws_pkg::N_SET*32-1:0]   act_q; // active group

  assign hit0    = grp_hit(addr, cws_pkg::A_GRP0);
  assign hit1    = grp_hit(addr, cws_pkg::A_GRP1);
  assign set_wr  = wr_stb && (hit0 || hit1);
  assign set_idx = hit1 ? 3'(addr - cws_pkg::A_GRP1 >> 2)
                        : 3'(addr - cws_pkg::A_GRP0 >> 2);

  // settings written any time, even mid supervision
  cws_setting_bank u_bank (
    .clk     (clk),
    .rst_b   (rst_b),
    .wr_en   (set_wr),                     // [RQ16]
    .wr_grp  (hit1),
    .wr_idx  (set_idx),
    .wr_data (wr_data),
    .act_grp (ctrl_r[cws_pkg::C_GRP]),     // [RQ16]
    .all_q   (all_q),
    .act_q   (act_q)
  );

  // active settings, hundredths of In or percent
  logic [CW-1:0] thr_high;  // phase ceiling
  logic [CW-1:0] thr_low;   // phase floor
  logic [CW-1:0] thr_rat;   // min/max ratio
  logic [CW-1:0] thr_seq;   // neg/pos ratio
  logic [CW-1:0] thr_sum;   // residual mismatch
  logic [31:0]   dly;       // program cycles

  assign thr_high = CW'(act_q[cws_pkg::S_HIGH*32 +: MW]); // [RQ23]
  assign thr_low  = CW'(act_q[cws_pkg::S_LOW*32  +: MW]);
  assign thr_rat  = CW'(act_q[cws_pkg::S_RAT*32  +: MW]);
  assign thr_seq  = CW'(act_q[cws_pkg::S_SEQ*32  +: MW]);
  assign thr_sum  = CW'(act_q[cws_pkg::S_SUM*32  +: MW]);
  // delay clamps to the 1800 s ceiling
  assign dly = (act_q[cws_pkg::S_DLY*32 +: 32] > cws_pkg::DLY_MAX)
             ? cws_pkg::DLY_MAX
             : act_q[cws_pkg::S_DLY*32 +: 32];            // [RQ9]

  // ==========================================
  // residual source and difference
  logic [1:0]       res_sel;  // source select
  logic             res_sub;  // subtract polarity
  logic             res_use;  // a channel chosen
  logic [MW-1:0]    res_m;    // chosen magnitude
  logic [MW-1:0]    res_a;    // chosen angle
  logic [MW-1:0]    mag_dif;  // |sum - residual|
  logic signed [cws_pkg::ANG_W-1:0] ang_raw; // unwrapped
  logic signed [cws_pkg::ANG_W-1:0] ang_dif; // wrapped

  assign res_sel = ctrl_r[cws_pkg::C_RES +: 2];
  assign res_sub = ctrl_r[cws_pkg::C_POL];
  assign res_use = (res_sel == cws_pkg::RES_ONE) ||
                   (res_sel == cws_pkg::RES_TWO);   // [RQ21]
  assign res_m   = (res_sel == cws_pkg::RES_TWO) ? res_two
                                                 : res_one;
  assign res_a   = (res_sel == cws_pkg::RES_TWO) ? res_two_a
                                                 : res_one_a;
  assign mag_dif = (sum_mag > res_m) ? sum_mag - res_m
                                     : res_m - sum_mag; // [RQ17]
  // subtract polarity turns the residual half a turn
  assign ang_raw = $signed({2'b00, sum_ang}) - $signed({2'b00, res_a})
                 - (res_sub ? cws_pkg::HALF_TURN : '0);  // [RQ21]
  assign ang_dif = (ang_raw < -cws_pkg::FULL_TURN)
                 ? ang_raw + cws_pkg::FULL_TURN : ang_raw;

  // ==========================================
  // per-phase threshold flags
  logic [2:0] hi_r;    // phase above ceiling
  logic [2:0] lo_r;    // phase above floor
  logic [2:0] hi_nxt;
  logic [2:0] lo_nxt;

  genvar p;
  generate
    for (p = 0; p < 3; p++)
    begin : g_ph
      // shared thresholds, each phase on its own
      assign hi_nxt[p] = cmp_over(CW'(meas_mag[p*MW +: MW]),
                                  thr_high, hi_r[p]); // [RQ1] [RQ3]
      assign lo_nxt[p] = cmp_over(CW'(meas_mag[p*MW +: MW]),
                                  thr_low, lo_r[p]);  // [RQ2]
    end
  endgenerate

  // ==========================================
  // ratio conditions by cross multiplication
  logic [MW-1:0] ph_min;  // smallest phase
  logic [MW-1:0] ph_max;  // largest phase
  logic [MW-1:0] m0, m1, m2;
  logic rat_r, seq_r, sum_r;
  logic rat_nxt, seq_nxt, sum_nxt;

  assign m0 = meas_mag[0 +: MW];
  assign m1 = meas_mag[MW +: MW];
  assign m2 = meas_mag[2*MW +: MW];
  assign ph_min = (m0 < m1) ? ((m0 < m2) ? m0 : m2)
                            : ((m1 < m2) ? m1 : m2);
  assign ph_max = (m0 > m1) ? ((m0 > m2) ? m0 : m2)
                            : ((m1 > m2) ? m1 : m2);
  // min*100.00% against setting*max avoids a divider
  assign rat_nxt = cmp_under(CW'(ph_min) * cws_pkg::FULL,
                             thr_rat * CW'(ph_max), rat_r);   // [RQ6]
  assign seq_nxt = cmp_over(CW'(seq_neg) * cws_pkg::FULL,
                            thr_seq * CW'(seq_pos), seq_r);   // [RQ7]
  assign sum_nxt = res_use &&
                   cmp_over(CW'(mag_dif), thr_sum, sum_r);    // [RQ8]

  // ==========================================
  // combined pick-up for this program cycle
  logic pick;     // every condition met
  logic cnd_high; // no phase above ceiling
  logic cnd_lo;   // at least one above floor
  logic cnd_un;   // at least one below floor
  logic cnd_sum;  // residual ok or unused

  assign cnd_high = ~|hi_nxt;                  // [RQ4]
  assign cnd_lo   = |lo_nxt;                   // [RQ5]
  assign cnd_un   = ~&lo_nxt;                  // [RQ19]
  assign cnd_sum  = !res_use || sum_nxt;       // [RQ8]
  assign pick = cnd_high && cnd_lo && cnd_un &&
                rat_nxt && seq_nxt && cnd_sum; // [RQ19]

  // comparison flags only move at cycle boundaries
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      hi_r  <= '0;
      lo_r  <= '0;
      rat_r <= 1'b0;
      seq_r <= 1'b0;
      sum_r <= 1'b0;
    end
    else if (tick)
    begin
      hi_r  <= hi_nxt;   // [RQ2]
      lo_r  <= lo_nxt;
      rat_r <= rat_nxt;
      seq_r <= seq_nxt;
      sum_r <= sum_nxt;
    end
  end

  // ==========================================
  // start / blocked / definite-time alarm
  cws_pkg::cws_state_e st_r;    // supervision state
  cws_pkg::cws_state_e st_nxt;
  logic [31:0] cnt_r;  // elapsed program cycles
  logic [31:0] cnt_nxt;
  logic        alm_nxt;
  logic        blk;    // blocking sampled at tick

  // blocking looked at only at the cycle start;
  // a late blocking cannot stop an expiring delay
  assign blk = block_in;                       // [RQ10] [RQ14]

  // state decode; any drop of pick-up resets timing
  always_comb
  begin
    st_nxt  = cws_pkg::ST_IDLE;
    cnt_nxt = '0;
    alm_nxt = 1'b0;
    if (!pick)
      st_nxt = cws_pkg::ST_IDLE;               // [RQ22]
    else if (blk)
      st_nxt = cws_pkg::ST_BLOCKED;            // [RQ12] [RQ13]
    else
    begin
      st_nxt  = cws_pkg::ST_START;             // [RQ11]
      // fixed count only, no inverse curve
      cnt_nxt = (st_r == cws_pkg::ST_START && cnt_r < dly)
              ? cnt_r + 32'h1
              : (st_r == cws_pkg::ST_START ? cnt_r : 32'h1); // [RQ15]
      alm_nxt = (cnt_nxt >= dly);              // [RQ22]
    end
  end

  // outputs update once per program cycle
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      st_r    <= cws_pkg::ST_IDLE;
      cnt_r   <= '0;
      start   <= 1'b0;
      alarm   <= 1'b0;
      blocked <= 1'b0;
    end
    else if (tick)
    begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      start   <= (st_nxt == cws_pkg::ST_START);   // [RQ11] [RQ13]
      alarm   <= alm_nxt;                         // [RQ22]
      blocked <= (st_nxt == cws_pkg::ST_BLOCKED); // [RQ12]
    end
  end

  // ==========================================
  // read-only measurement snapshots
  logic [MW-1:0]               sdif_r;  // magnitude diff
  logic [cws_pkg::ANG_W-1:0]   adif_r;  // angle diff
  logic [cws_pkg::ANG_W-1:0]   unba_r;  // unbalance angle

  // snapshot per cycle so software reads one set
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      sdif_r <= '0;
      adif_r <= '0;
      unba_r <= '0;
    end
    else if (tick)
    begin
      sdif_r <= mag_dif;           // [RQ17]
      adif_r <= ang_dif;           // [RQ17]
      unba_r <= unbal_ang;         // [RQ18]
    end
  end

  // ==========================================
  // control write and read mux
  logic [cws_pkg::DW-1:0] rd_mux;  // selected word
  logic [cws_pkg::DW-1:0] stat_w;  // status word
  logic [cws_pkg::AW-1:0] rel;     // offset in group

  assign stat_w = {22'h0, cnd_sum, seq_r, rat_r,
                   cnd_un, cnd_lo, cnd_high,
                   blocked, alarm, start,
                   (st_r != cws_pkg::ST_IDLE)};
  assign rel = hit1 ? addr - cws_pkg::A_GRP1
                    : addr - cws_pkg::A_GRP0;
  assign rd_mux =
    (addr == cws_pkg::A_CTRL) ? ctrl_r :
    (addr == cws_pkg::A_STAT) ? stat_w :
    (addr == cws_pkg::A_SDIF) ? 32'(sdif_r) :
    (addr == cws_pkg::A_ADIF) ? 32'($signed(adif_r)) :
    (addr == cws_pkg::A_UNBA) ? 32'($signed(unba_r)) :
    hit0 ? all_q[32'(rel) * 8 +: 32] :
    hit1 ? all_q[(32'(rel) + 4 * cws_pkg::N_SET) * 8 +: 32] :
    32'h0;  // unmapped reads zero

  // control register, low four bits live
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      ctrl_r <= '0;
    else if (wr_stb && addr == cws_pkg::A_CTRL)
      ctrl_r <= wr_data & 32'h0000_000F;  // [RQ21] [RQ16]
  end

  // read data for exactly the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      rd_data <= '0;
    else if (rd_stb)
      rd_data <= rd_mux;
    else
      rd_data <= '0;
  end

endmodule : cws_top

`default_nettype wire

// File: verification/cws_top_asserts.sv
// checker for the supervision core, watching only top-level ports
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none

module cws_top_asserts #(
  parameter int unsigned PCYC_CLKS = 20 // clocks per program cycle
) (
  input wire logic                     clk,      // 250 MHz
  input wire logic                     rst_b,    // sync reset
  input wire logic                     block_in, // blocking level
  input wire logic                     rd_stb,   // read strobe
  input wire logic [cws_pkg::DW-1:0]   rd_data,  // read data
  input wire logic                     start,    // start
  input wire logic                     alarm,    // alarm
  input wire logic                     blocked   // blocked
);
  // ==========================================
  // program cycle phase, mirrors the divider so ticks are known
  logic [31:0] cnt_r; // clocks since last tick
  logic [31:0] cnt_nxt; // next phase
  assign cnt_nxt = (cnt_r == PCYC_CLKS - 1) ? 32'h0 : cnt_r + 32'h1;
  // restarts with reset so the phase matches the design's divider
  always_ff @(posedge clk)
  begin
    cnt_r <= rst_b ? cnt_nxt : 32'h0;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ==========================================
  // assertions
  a_rd_idle_zero: assert property (!$past(rd_stb) |-> rd_data == 32'h0)
    else $error("read data not zero outside answer cycle");
  a_alarm_needs_start: assert property (alarm |-> start)
    else $error("alarm without start");
  a_start_blocked_excl: assert property (!(start && blocked))
    else $error("start and blocked together");
  a_blocked_cause: assert property ($rose(blocked) |-> $past(block_in) && !alarm)
    else $error("blocked rose without blocking input");
  a_start_cause: assert property ($rose(start) |-> !$past(block_in))
    else $error("start rose while blocking input high");
  a_fall_clears_alarm: assert property ($fell(start) |-> !alarm)
    else $error("alarm stayed after start dropped");
  a_tick_only_change: assert property (
    ($changed(start) || $changed(alarm) || $changed(blocked)) |-> cnt_r == 32'h0)
    else $error("output changed between program ticks");
  a_block_hold: assert property (blocked && block_in |=> !start)
    else $error("start while blocking stays high");
  c_alarm_seen: cover property ($rose(alarm));
endmodule : cws_top_asserts

bind cws_top cws_top_asserts #(.PCYC_CLKS(PCYC_CLKS)) i_cws_top_asserts (
  .clk(clk), .rst_b(rst_b), .block_in(block_in), .rd_stb(rd_stb),
  .rd_data(rd_data), .start(start), .alarm(alarm), .blocked(blocked)
);

`default_nettype wire

// File: verification/cws_channel_model.sv
// measurement channels and blocking source feeding the core
// assumes the core's divider phase; values refresh mid program cycle
`timescale 1ns/1ps
`default_nettype none

module cws_channel_model #(
  parameter int unsigned PCYC_CLKS = 20 // clocks per program cycle
) (
  input  wire logic         clk,   // 250 MHz
  input  wire logic         rst_b, // sync reset
  input  wire logic [47:0]  q_ph,  // requested phase magnitudes
  input  wire logic [79:0]  q_mag, // pos, neg, sum, res1, res2
  input  wire logic [17:0]  q_ua,  // requested unbalance angle
  input  wire logic         q_blk, // requested blocking
  output logic      [47:0]  ph,    // phase magnitudes
  output logic      [79:0]  mag,   // pos, neg, sum, res1, res2
  output logic      [17:0]  ua,    // unbalance angle
  output logic              blk    // blocking level
);
  // ==========================================
  // refresh at half cycle so values stand still around every tick
  logic [31:0] div_r; // phase counter
  always_ff @(posedge clk)
  begin
    div_r <= (!rst_b || div_r == PCYC_CLKS - 1) ? 32'h0 : div_r + 32'h1;
  end
  // one refresh per 5 ms cycle blocking lands half a cycle before a tick
  always_ff @(posedge clk)
  begin
    if (div_r == PCYC_CLKS / 2)
    begin
      ph  <= q_ph;
      mag <= q_mag;
      ua  <= q_ua;
      blk <= q_blk;
    end
  end
endmodule : cws_channel_model

`default_nettype wire

// File: verification/tb_ct_wiring_supervision.sv
// self-checking bench for the supervision core
// assumes default settings after reset and a shortened program cycle
`timescale 1ns/1ps
`default_nettype none

module tb_ct_wiring_supervision;
  localparam int unsigned P = 20; // clocks per program cycle
  logic        clk = 1'b0, rst_b = 1'b0; // clock and reset
  logic [7:0]  addr = 8'h00; // register address
  logic [31:0] wr_data = 32'h0; // write data
  logic        wr_stb = 1'b0, rd_stb = 1'b0; // strobes
  logic [47:0] q_ph = 48'h0; // requested phases
  logic [79:0] q_mag = 80'h0; // requested other magnitudes
  logic [17:0] q_ua = 18'h37360; // minus 360.00 degrees
  logic        q_blk = 1'b0; // requested blocking
  wire logic [31:0] rd_data; // read data
  wire logic [47:0] ph; // phases to core
  wire logic [79:0] mag; // magnitudes to core
  wire logic [17:0] ua; // angle to core
  wire logic        blk, start, alarm, blocked; // levels
  int num_errors = 0, checks_done = 0; // tallies
  localparam logic [31:0] DEF [6] = '{cws_pkg::D_HIGH, cws_pkg::D_LOW, cws_pkg::D_RAT,
                                      cws_pkg::D_SEQ, cws_pkg::D_SUM, cws_pkg::D_DLY}; // defaults

  always #2 clk = ~clk;

  cws_channel_model #(.PCYC_CLKS(P)) i_cws_channel_model (.clk(clk), .rst_b(rst_b), .q_ph(q_ph),
    .q_mag(q_mag), .q_ua(q_ua), .q_blk(q_blk), .ph(ph), .mag(mag), .ua(ua), .blk(blk));
  cws_top #(.PCYC_CLKS(P)) i_cws_top (.clk(clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .meas_mag(ph), .res_one(mag[63:48]),
    .res_two(mag[79:64]), .seq_pos(mag[15:0]), .seq_neg(mag[31:16]), .sum_mag(mag[47:32]),
    .sum_ang(16'h0000), .res_one_a(16'h0000), .res_two_a(16'h0000), .unbal_ang(ua),
    .block_in(blk), .start(start), .alarm(alarm), .blocked(blocked));

  // ==========================================
  // access and compare tasks
  task automatic chk32(input logic [31:0] got, exp, msk);
    checks_done++;
    if ((got & msk) !== (exp & msk))
    begin
      num_errors++;
      $display("mismatch at %0t: data %h expected %h", $time, got, exp);
    end
  endtask : chk32
  task automatic chk_out(input logic [2:0] exp);
    checks_done++;
    if ({start, alarm, blocked} !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: outputs %b expected %b", $time, {start, alarm, blocked}, exp);
    end
  endtask : chk_out
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_stb  <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge clk);
    wr_stb  <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, msk);
    @(posedge clk);
    rd_stb <= 1'b1;
    addr   <= a;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 chk32(rd_data, exp, msk);
  endtask : rd
  // hand new values to the channels and let three ticks pass
  task automatic scen(input logic [47:0] p, input logic [79:0] m, input logic b);
    q_ph  <= p;
    q_mag <= m;
    q_blk <= b;
    repeat (3 * P) @(posedge clk);
    #1;
  endtask : scen
  task automatic results;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  // ==========================================
  // broken phase one: pos 0.67, neg 0.33, sum 1.00
  localparam logic [47:0] BRK = {16'h64, 16'h64, 16'h00}; // phases
  localparam logic [79:0] SEQ = {16'h0000, 16'h0000, 16'h0064, 16'h0021, 16'h0043}; // no residual

  initial
  begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      rd(cws_pkg::A_GRP0 + 8'(4 * i), DEF[i], 32'hFFFFFFFF);
      rd(cws_pkg::A_GRP1 + 8'(4 * i), DEF[i], 32'hFFFFFFFF);
    end
    rd(cws_pkg::A_CTRL, 32'h0, 32'hFFFFFFFF);
    rd(8'hFC, 32'h0, 32'hFFFFFFFF);
    scen({16'h64, 16'h64, 16'h64}, {48'h0, 16'h0000, 16'h0064}, 1'b0);
    chk_out(3'b000);
    rd(cws_pkg::A_UNBA, 32'hFFFF7360, 32'hFFFFFFFF);
    wr(cws_pkg::A_GRP0 + 8'h14, 32'h4);
    q_ph  <= BRK;
    q_mag <= SEQ;
    for (int i = 0; i < 5 * P && start !== 1'b1; i++)
      #4;
    @(posedge clk);
    #1;
    repeat (2 * P) @(posedge clk);
    #1 chk_out(3'b100);
    repeat (P) @(posedge clk);
    #1 chk_out(3'b110);
    rd(cws_pkg::A_STAT, 32'h1F7, 32'h1FF);
    scen(BRK, SEQ, 1'b1);
    chk_out(3'b001);
    scen(BRK, SEQ, 1'b0);
    chk_out(3'b100);
    scen({16'h82, 16'h64, 16'h00}, SEQ, 1'b0);
    chk_out(3'b000);
    scen({16'h05, 16'h09, 16'h00}, {48'h0, 16'h0003, 16'h0004}, 1'b1);
    chk_out(3'b000);
    scen(BRK, SEQ, 1'b1);
    chk_out(3'b001);
    wr(cws_pkg::A_CTRL, 32'h1);
    scen(BRK, {16'h0000, 16'h0064, SEQ[47:0]}, 1'b0);
    chk_out(3'b000);
    scen(BRK, SEQ, 1'b0);
    chk_out(3'b100);
    rd(cws_pkg::A_SDIF, 32'h64, 32'hFFFFFFFF);
    wr(cws_pkg::A_CTRL, 32'h6);
    scen(BRK, {16'h0000, 16'h0064, SEQ[47:0]}, 1'b0);
    chk_out(3'b110);
    rd(cws_pkg::A_ADIF, 32'hFFFFB9B0, 32'hFFFFFFFF);
    wr(cws_pkg::A_GRP1, 32'h50);
    wr(cws_pkg::A_CTRL, 32'h8);
    scen(BRK, SEQ, 1'b0);
    chk_out(3'b000);
    scen({16'h4F, 16'h4F, 16'h00}, SEQ, 1'b0);
    chk_out(3'b000);
    scen({16'h4D, 16'h4D, 16'h00}, SEQ, 1'b0);
    chk_out(3'b100);
    results();
  end

  // watchdog: the sequence needs roughly 40 program cycles
  initial
  begin
    #(4 * P * 200 * 4);
    num_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    results();
  end
endmodule : tb_ct_wiring_supervision

`default_nettype wire
